// >>> rtl/rrirq_regs.sv
// Register bank: receive filter and gain, regulator and I/O, interrupt cause, mask and collision position.
// Assumes a host register port on clk_sys_i and protocol events already synchronous to clk_sys_i.
// Notes on behaviour
// - Filter and gain register loads 0x40 on reset, enable low, protocol control write.
// - Bits 7, 6, 5 choose 212k, 424k and Manchester 848k band-pass.
// - High-bit-rate bit picks widest band and cuts gain 7 dB.
// - Gain field 01, 10, 11 cuts 5, 10, 15 dB; 00 none.
// - AGC threshold bit moves trigger from five to three times digitizing level.
// - Unlimited-AGC bit lets gain control act during whole reception.
// - Regulator register loads 0x87 on reset or enable low only.
// - Regulator mode bit: 0 manual voltage bits, 1 automatic.
// - External amplifier bit takes demodulated input and drives modulation pin.
// - Cause register clears after a read, withdrawing the interrupt request.
// - Any cause register reset withdraws pending interrupt request.
// - Transmit cause set at start; request issued at transmit end.
// - Receive cause set at start of frame; request at reception end.
// - FIFO cause set when FIFO holds under 4 or over 8 bytes.
// - Separate cause bits for CRC, parity and framing errors.
// - Collision cause bit reports a detected bit collision.
// - No-response cause tells host next slot command may be sent.
// - Six mask bits enable FIFO, CRC, parity, framing, collision, no-response.
// - Ten-bit position: bits 9..8 in mask register, 7..0 low register.
// - Low position register resets zero, clears after read, reports error position.
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
`include "rrirq_defs.svh"

module rrirq_regs (
  // Clock and reset
  input  wire logic                   clk_sys_i,
  input  wire logic                   sys_rst_i,
  // Device enable pin, asynchronous
  input  wire logic                   enable_pin_i,
  // Host register port
  input  wire rrirq_pkg::rrirq_req_type req_i,
  input  wire logic                   proto_ctrl_wr_i,
  output logic [7:0]                  rdata_o,
  // Protocol events and FIFO fill level
  input  wire rrirq_pkg::rrirq_evt_type evt_i,
  input  wire logic [3:0]             fifo_level_i,
  input  wire logic                   fifo_level_vld_i,
  // Outputs to analog and host
  output rrirq_pkg::rrirq_ana_type    ana_o,
  output logic                        irq_o
);
  import rrirq_pkg::*;

  logic [7:0] rx_filter_gain_setting;
  logic [7:0] regulator_io_control;
  logic [7:0] interrupt_cause;
  logic [7:0] collision_high_and_irq_mask;
  logic [7:0] collision_position_low;
  logic       en_meta;
  logic       en_sync;
  logic       tx_busy;
  logic       rx_busy;
  logic       clr_all;
  logic       rd_cause;
  logic       rd_pos_hi;
  logic       rd_pos_lo;
  logic [7:0] next_rdata;
  logic [7:0] cause_set;
  logic       next_irq;

  // Gain reduction in dB from the two-bit code
  function automatic logic [4:0] gain_cut_db(input logic [1:0] code);
    unique case (code)
      2'b01:   gain_cut_db = `RRIRQ_GAIN_CUT_DB_01;
      2'b10:   gain_cut_db = `RRIRQ_GAIN_CUT_DB_10;
      2'b11:   gain_cut_db = `RRIRQ_GAIN_CUT_DB_11;
      default: gain_cut_db = 5'h00;
    endcase
  endfunction : gain_cut_db

  // Enable pin synchroniser; low enable acts as a reset of the bank
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      en_meta <= 1'b0;
      en_sync <= 1'b0;
    end else begin
      en_meta <= enable_pin_i;
      en_sync <= en_meta;
    end
  end

  assign clr_all   = sys_rst_i | ~en_sync;
  assign rd_cause  = req_i.rd && (req_i.addr == `RRIRQ_OFF_INTERRUPT_CAUSE);
  assign rd_pos_hi = req_i.rd && (req_i.addr == `RRIRQ_OFF_CLASH_HIGH_MASK);
  assign rd_pos_lo = req_i.rd && (req_i.addr == `RRIRQ_OFF_CLASH_POS_LOW);

  // Receive filter and gain register
  always_ff @(posedge clk_sys_i) begin
    if (clr_all || proto_ctrl_wr_i) begin
      rx_filter_gain_setting <= `RRIRQ_RST_RX_FILTER_GAIN;
    end else if (req_i.wr && req_i.addr == `RRIRQ_OFF_RX_FILTER_GAIN) begin
      rx_filter_gain_setting <= req_i.wdata;
    end
  end

  // Regulator register; protocol control writes leave it alone
  always_ff @(posedge clk_sys_i) begin
    if (clr_all) begin
      regulator_io_control <= `RRIRQ_RST_REGULATOR_IO;
    end else if (req_i.wr && req_i.addr == `RRIRQ_OFF_REGULATOR_IO) begin
      regulator_io_control <= {req_i.wdata[7:5], 2'b00, req_i.wdata[2:0]};
    end
  end

  // Decoded settings, registered so every output comes from a flip-flop
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      ana_o <= '0;
    end else begin
      ana_o.filter_sel_212k       <= rx_filter_gain_setting[`RRIRQ_BIT_FILTER_212K];
      ana_o.filter_sel_424k       <= rx_filter_gain_setting[`RRIRQ_BIT_FILTER_424K];
      ana_o.filter_sel_manch_848k <= rx_filter_gain_setting[`RRIRQ_BIT_FILTER_848K];
      ana_o.filter_wide_hbr       <= rx_filter_gain_setting[`RRIRQ_BIT_HIGH_BIT_RATE];
      // High bit rate adds its fixed cut on top of the coded cut
      ana_o.gain_cut_db <= gain_cut_db({rx_filter_gain_setting[`RRIRQ_BIT_GAIN_CUT_A],
                                        rx_filter_gain_setting[`RRIRQ_BIT_GAIN_CUT_B]})
                           + (rx_filter_gain_setting[`RRIRQ_BIT_HIGH_BIT_RATE]
                              ? `RRIRQ_GAIN_CUT_DB_HBR : 5'h00);
      ana_o.agc_mult <= rx_filter_gain_setting[`RRIRQ_BIT_AGC_LOW_LEVEL]
                        ? `RRIRQ_AGC_MULT_LOW : `RRIRQ_AGC_MULT_HIGH;
      ana_o.agc_any_time         <= rx_filter_gain_setting[`RRIRQ_BIT_AGC_UNLIMITED];
      ana_o.regulator_auto       <= regulator_io_control[`RRIRQ_BIT_AUTO_REGULATOR];
      ana_o.voltage_set          <= regulator_io_control[2:0];
      ana_o.external_amp_support <= regulator_io_control[`RRIRQ_BIT_EXT_AMP];
      ana_o.io_low               <= regulator_io_control[`RRIRQ_BIT_IO_LOW];
    end
  end

  // Cause bits that hardware sets this cycle
  always_comb begin
    cause_set = 8'h00;
    cause_set[`RRIRQ_BIT_CAUSE_TX]        = evt_i.tx_start;
    cause_set[`RRIRQ_BIT_CAUSE_RX]        = evt_i.rx_sof;
    cause_set[`RRIRQ_BIT_CAUSE_FIFO]      = fifo_level_vld_i &&
                                            (fifo_level_i < `RRIRQ_FIFO_LOW_BOUND ||
                                             fifo_level_i > `RRIRQ_FIFO_HIGH_BOUND);
    cause_set[`RRIRQ_BIT_CAUSE_CRC]       = evt_i.crc_err;
    cause_set[`RRIRQ_BIT_CAUSE_PARITY]    = evt_i.parity_err;
    cause_set[`RRIRQ_BIT_CAUSE_FRAMING]   = evt_i.framing_err;
    cause_set[`RRIRQ_BIT_CAUSE_COLLISION] = evt_i.collision;
    cause_set[`RRIRQ_BIT_CAUSE_NORESP]    = evt_i.no_resp;
  end

  // Cause register: cleared by reset, protocol write or read; a new event wins over the read clear
  always_ff @(posedge clk_sys_i) begin
    if (clr_all || proto_ctrl_wr_i) begin
      interrupt_cause <= `RRIRQ_RST_INTERRUPT_CAUSE;
    end else if (rd_cause) begin
      interrupt_cause <= cause_set;
    end else begin
      interrupt_cause <= interrupt_cause | cause_set;
    end
  end

  // Transmit and receive in progress; their request waits for the end
  always_ff @(posedge clk_sys_i) begin
    if (clr_all || proto_ctrl_wr_i) begin
      tx_busy <= 1'b0;
      rx_busy <= 1'b0;
    end else begin
      if (evt_i.tx_start) begin
        tx_busy <= 1'b1;
      end else if (evt_i.tx_end) begin
        tx_busy <= 1'b0;
      end
      if (evt_i.rx_sof) begin
        rx_busy <= 1'b1;
      end else if (evt_i.rx_end) begin
        rx_busy <= 1'b0;
      end
    end
  end

  // Request condition from the stored cause and mask
  always_comb begin
    next_irq = ((interrupt_cause[`RRIRQ_BIT_CAUSE_TX] && !tx_busy) ||
                (interrupt_cause[`RRIRQ_BIT_CAUSE_RX] && !rx_busy) ||
                |(interrupt_cause[5:0] & collision_high_and_irq_mask[5:0]));
  end

  // Request drops in the same cycle as any cause clear
  always_ff @(posedge clk_sys_i) begin
    if (clr_all || proto_ctrl_wr_i || rd_cause) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= next_irq;
    end
  end

  // Mask bits and high collision position bits
  always_ff @(posedge clk_sys_i) begin
    if (clr_all) begin
      collision_high_and_irq_mask <= `RRIRQ_RST_CLASH_HIGH_MASK;
    end else begin
      if (req_i.wr && req_i.addr == `RRIRQ_OFF_CLASH_HIGH_MASK) begin
        collision_high_and_irq_mask[5:0] <= req_i.wdata[5:0];
      end
      // New position wins over a read clear
      if (evt_i.pos_valid) begin
        collision_high_and_irq_mask[7:6] <= evt_i.pos[9:8];
      end else if (rd_pos_hi) begin
        collision_high_and_irq_mask[7:6] <= 2'b00;
      end
    end
  end

  // Low collision or error position
  always_ff @(posedge clk_sys_i) begin
    if (clr_all) begin
      collision_position_low <= `RRIRQ_RST_CLASH_POS_LOW;
    end else if (evt_i.pos_valid) begin
      collision_position_low <= evt_i.pos[7:0];
    end else if (rd_pos_lo) begin
      collision_position_low <= 8'h00;
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    unique case (req_i.addr)
      `RRIRQ_OFF_RX_FILTER_GAIN:  next_rdata = rx_filter_gain_setting;
      `RRIRQ_OFF_REGULATOR_IO:    next_rdata = regulator_io_control;
      `RRIRQ_OFF_INTERRUPT_CAUSE: next_rdata = interrupt_cause;
      `RRIRQ_OFF_CLASH_HIGH_MASK: next_rdata = collision_high_and_irq_mask;
      `RRIRQ_OFF_CLASH_POS_LOW:   next_rdata = collision_position_low;
      default:                    next_rdata = 8'h00;
    endcase
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      rdata_o <= 8'h00;
    end else if (req_i.rd) begin
      rdata_o <= next_rdata;
    end else begin
      rdata_o <= 8'h00;
    end
  end
endmodule : rrirq_regs

// >>> rtl/rrirq_defs.svh
// Register offsets, field positions and reset values of the receive, regulator and interrupt cause registers.
// Assumes inclusion by the register bank only.
`ifndef RRIRQ_DEFS_SVH
`define RRIRQ_DEFS_SVH
`define RRIRQ_OFF_RX_FILTER_GAIN   8'h0a
`define RRIRQ_OFF_REGULATOR_IO     8'h0b
`define RRIRQ_OFF_INTERRUPT_CAUSE  8'h0c
`define RRIRQ_OFF_CLASH_HIGH_MASK  8'h0d
`define RRIRQ_OFF_CLASH_POS_LOW    8'h0e
`define RRIRQ_RST_RX_FILTER_GAIN   8'h40
`define RRIRQ_RST_REGULATOR_IO     8'h87
`define RRIRQ_RST_INTERRUPT_CAUSE  8'h00
`define RRIRQ_RST_CLASH_HIGH_MASK  8'h3e
`define RRIRQ_RST_CLASH_POS_LOW    8'h00
// Receive filter and gain fields
`define RRIRQ_BIT_FILTER_212K      7
`define RRIRQ_BIT_FILTER_424K      6
`define RRIRQ_BIT_FILTER_848K      5
`define RRIRQ_BIT_HIGH_BIT_RATE    4
`define RRIRQ_BIT_GAIN_CUT_A       3
`define RRIRQ_BIT_GAIN_CUT_B       2
`define RRIRQ_BIT_AGC_LOW_LEVEL    1
`define RRIRQ_BIT_AGC_UNLIMITED    0
// Regulator and I/O fields
`define RRIRQ_BIT_AUTO_REGULATOR   7
`define RRIRQ_BIT_EXT_AMP          6
`define RRIRQ_BIT_IO_LOW           5
// Interrupt cause fields; mask bits share positions 5..0
`define RRIRQ_BIT_CAUSE_TX         7
`define RRIRQ_BIT_CAUSE_RX         6
`define RRIRQ_BIT_CAUSE_FIFO       5
`define RRIRQ_BIT_CAUSE_CRC        4
`define RRIRQ_BIT_CAUSE_PARITY     3
`define RRIRQ_BIT_CAUSE_FRAMING    2
`define RRIRQ_BIT_CAUSE_COLLISION  1
`define RRIRQ_BIT_CAUSE_NORESP     0
// FIFO level bounds for the FIFO cause
`define RRIRQ_FIFO_LOW_BOUND       4'h4
`define RRIRQ_FIFO_HIGH_BOUND      4'h8
// Gain reduction codes in dB, and the extra cut of high bit rate
`define RRIRQ_GAIN_CUT_DB_01       5'h05
`define RRIRQ_GAIN_CUT_DB_10       5'h0a
`define RRIRQ_GAIN_CUT_DB_11       5'h0f
`define RRIRQ_GAIN_CUT_DB_HBR      5'h07
// AGC trigger multiples of the digitizing level
`define RRIRQ_AGC_MULT_LOW         3'h3
`define RRIRQ_AGC_MULT_HIGH        3'h5
`endif

// >>> rtl/rrirq_pkg.sv
// Types shared by the register bank and its users.
// Assumes rrirq_defs.svh on the include path.
package rrirq_pkg;
  // Host register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } rrirq_req_type;

  // Transmit and receive events, one-cycle pulses from protocol logic
  typedef struct packed {
    logic       tx_start;
    logic       tx_end;
    logic       rx_sof;
    logic       rx_end;
    logic       crc_err;
    logic       parity_err;
    logic       framing_err;
    logic       collision;
    logic       no_resp;
    logic       pos_valid;
    logic [9:0] pos;
  } rrirq_evt_type;

  // Decoded analog settings
  typedef struct packed {
    logic       filter_sel_212k;
    logic       filter_sel_424k;
    logic       filter_sel_manch_848k;
    logic       filter_wide_hbr;
    logic [4:0] gain_cut_db;
    logic [2:0] agc_mult;
    logic       agc_any_time;
    logic       regulator_auto;
    logic [2:0] voltage_set;
    logic       external_amp_support;
    logic       io_low;
  } rrirq_ana_type;
endpackage : rrirq_pkg

// >>> bench/rrirq_props.sv
// Port-level properties of the register bank.
// Assumes enable stays high around host writes and proto control pulses.
`timescale 1ns/1ps
module rrirq_props (
  // Clock, reset, enable
  input wire logic                     clk_sys_i,
  input wire logic                     sys_rst_i,
  input wire logic                     enable_pin_i,
  // Host port and events
  input wire rrirq_pkg::rrirq_req_type req_i,
  input wire logic                     proto_ctrl_wr_i,
  input wire logic [7:0]               rdata_o,
  input wire rrirq_pkg::rrirq_evt_type evt_i,
  input wire logic [3:0]               fifo_level_i,
  input wire logic                     fifo_level_vld_i,
  // Outputs
  input wire rrirq_pkg::rrirq_ana_type ana_o,
  input wire logic                     irq_o
);
  import rrirq_pkg::*;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  // Decoded accesses; position reads exclude a same-cycle update
  logic rd_c, rd_d, rd_e, wr_a, wr_b, ev;
  assign rd_c = req_i.rd && req_i.addr == 8'h0c;
  assign rd_d = req_i.rd && req_i.addr == 8'h0d && !evt_i.pos_valid;
  assign rd_e = req_i.rd && req_i.addr == 8'h0e && !evt_i.pos_valid;
  assign wr_a = req_i.wr && req_i.addr == 8'h0a;
  assign wr_b = req_i.wr && req_i.addr == 8'h0b;
  // Every cause that may raise the request; starts of transfers are absent on purpose
  assign ev = evt_i.tx_end | evt_i.rx_end | evt_i.crc_err | evt_i.parity_err | evt_i.framing_err | evt_i.collision
    | evt_i.no_resp | evt_i.pos_valid | (fifo_level_vld_i && (fifo_level_i < 4'h4 || fifo_level_i > 4'h8))
    | (req_i.wr && req_i.addr == 8'h0d);
  // Expected total gain cut of a filter and gain byte
  function automatic logic [4:0] cut(logic [7:0] w);
    return 5'h05 * w[3:2] + (w[4] ? 5'h07 : 5'h00);
  endfunction : cut
  property p_rd_clear; rd_c |=> !irq_o; endproperty
  a_rd_clear: assert property (p_rd_clear) else $error("irq held after cause read");
  property p_proto_irq; proto_ctrl_wr_i |=> !irq_o; endproperty
  a_proto_irq: assert property (p_proto_irq) else $error("irq held after proto write");
  property p_pos_low; rd_e ##1 !evt_i.pos_valid ##1 rd_e |=> rdata_o == 8'h00; endproperty
  a_pos_low: assert property (p_pos_low) else $error("low position kept");
  property p_pos_high; rd_d ##1 !evt_i.pos_valid ##1 rd_d |=> rdata_o == {2'h0, $past(rdata_o[5:0], 2)}; endproperty
  a_pos_high: assert property (p_pos_high) else $error("high position kept or mask lost");
  property p_irq_cause; $rose(irq_o) |-> $past(ev) || $past(ev, 2); endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq without cause");
  property p_wr_fg;
    wr_a && !proto_ctrl_wr_i |-> ##2 {ana_o.filter_sel_212k, ana_o.filter_sel_424k, ana_o.filter_sel_manch_848k,
      ana_o.filter_wide_hbr, ana_o.gain_cut_db, ana_o.agc_mult, ana_o.agc_any_time} == {$past(req_i.wdata[7:4], 2),
      cut($past(req_i.wdata, 2)), $past(req_i.wdata[1], 2) ? 3'h3 : 3'h5, $past(req_i.wdata[0], 2)};
  endproperty
  a_wr_fg: assert property (p_wr_fg) else $error("filter decode wrong");
  property p_wr_reg; wr_b |-> ##2 {ana_o.regulator_auto, ana_o.external_amp_support, ana_o.io_low, ana_o.voltage_set}
    == {$past(req_i.wdata[7:5], 2), $past(req_i.wdata[2:0], 2)}; endproperty
  a_wr_reg: assert property (p_wr_reg) else $error("regulator decode wrong");
  property p_proto_fg; proto_ctrl_wr_i && !wr_a ##1 !wr_a |=> ana_o.filter_sel_424k && !ana_o.filter_sel_212k
    && ana_o.gain_cut_db == 5'h00 && ana_o.agc_mult == 3'h5; endproperty
  a_proto_fg: assert property (p_proto_fg) else $error("filter not reloaded");
  property p_proto_reg; proto_ctrl_wr_i && !wr_b && !$past(wr_b) ##1 !wr_b |=> {ana_o.regulator_auto,
    ana_o.voltage_set} == $past({ana_o.regulator_auto, ana_o.voltage_set}, 2); endproperty
  a_proto_reg: assert property (p_proto_reg) else $error("regulator disturbed");
  // Main scenarios reached
  c_rd_irq: cover property (rd_c && irq_o);
  c_pos: cover property (evt_i.pos_valid);
  c_proto: cover property (proto_ctrl_wr_i && irq_o);
endmodule : rrirq_props

// >>> bench/rrirq_host.sv
// Host model: one-cycle write and read strobes on the register port.
// Assumes read data stand only in the cycle after the strobe; no wait states.
`timescale 1ns/1ps
module rrirq_host (
  // Clock
  input  wire logic               clk_sys_i,
  // Register port
  output rrirq_pkg::rrirq_req_type req_o,
  input  wire logic [7:0]         rdata_i
);
  import rrirq_pkg::*;
  // Idle port, strobes low
  initial req_o = '0;
  // Strobe drops at the taking edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    req_o <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys_i);
    req_o <= '0;
  endtask : wr
  // Data sampled inside the single answer cycle
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys_i);
    req_o <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys_i);
    req_o <= '0;
    #1;
    d = rdata_i;
  endtask : rd
endmodule : rrirq_host

// >>> bench/testbench.sv
// Self-checking bench: host model on the register port, events driven here.
// Assumes bank, host model and checker compiled first.
`timescale 1ns/1ps
module testbench;
  import rrirq_pkg::*;
  logic          clk_sys_i, sys_rst_i, enable_pin_i, proto_ctrl_wr_i, fifo_level_vld_i, irq_o;
  logic [3:0]    fifo_level_i;
  logic [7:0]    rdata_o;
  rrirq_req_type req_i;
  rrirq_evt_type evt_i;
  rrirq_ana_type ana_o;
  int            bad_count = 0;
  int            n_tests = 0;
  rrirq_regs i_rrirq_regs (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .enable_pin_i(enable_pin_i),
    .req_i(req_i), .proto_ctrl_wr_i(proto_ctrl_wr_i), .rdata_o(rdata_o), .evt_i(evt_i),
    .fifo_level_i(fifo_level_i), .fifo_level_vld_i(fifo_level_vld_i), .ana_o(ana_o), .irq_o(irq_o));
  rrirq_host i_rrirq_host (.clk_sys_i(clk_sys_i), .req_o(req_i), .rdata_i(rdata_o));
  // 200 MHz clock
  initial begin
    clk_sys_i = 1'b0;
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end
  // Compare and count
  task automatic check(string what, logic [7:0] exp, logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : check
  // Land one past the edge so updates have settled
  task automatic step(int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask : step
  task automatic rdc(logic [7:0] a, logic [7:0] exp);
    logic [7:0] v;
    i_rrirq_host.rd(a, v);
    check($sformatf("reg %h", a), exp, v);
  endtask : rdc
  task automatic chk_irq(logic exp);
    check("irq", {7'h0, exp}, {7'h0, irq_o});
  endtask : chk_irq
  // Bit 11 of the carrier is no-response; higher indexes walk up to transmit start
  function automatic rrirq_evt_type ev(int i);
    return rrirq_evt_type'(20'h00800 << i);
  endfunction : ev
  task automatic pulse(rrirq_evt_type e);
    @(posedge clk_sys_i);
    evt_i <= e;
    @(posedge clk_sys_i);
    evt_i <= '0;
  endtask : pulse
  task automatic proto();
    @(posedge clk_sys_i);
    proto_ctrl_wr_i <= 1'b1;
    @(posedge clk_sys_i);
    proto_ctrl_wr_i <= 1'b0;
    #1;
  endtask : proto
  task automatic t_defaults();
    rdc(8'h0a, 8'h40);
    rdc(8'h0b, 8'h87);
    rdc(8'h0d, 8'h3e);
    i_rrirq_host.wr(8'h0c, 8'hff);
    rdc(8'h0c, 8'h00);
    i_rrirq_host.wr(8'h0e, 8'hff);
    rdc(8'h0e, 8'h00);
    rdc(8'h0f, 8'h00);
  endtask : t_defaults
  // Filter, gain and regulator codes, then proto control reload
  task automatic t_settings();
    logic [7:0] w;
    for (int c = 0; c < 8; c++) begin
      w = {c[2] ? 3'h1 : 3'h6, c[2], c[1:0], c[0], c[1]};
      i_rrirq_host.wr(8'h0a, w);
      step(1);
      check("gain", {3'h0, 5'h05 * c[1:0] + (c[2] ? 5'h07 : 5'h00)}, {3'h0, ana_o.gain_cut_db});
      rdc(8'h0a, w);
    end
    i_rrirq_host.wr(8'h0b, 8'h7f);
    rdc(8'h0b, 8'h67);
    proto();
    rdc(8'h0a, 8'h40);
    rdc(8'h0b, 8'h67);
  endtask : t_settings
  // Each error cause masked, then enabled
  task automatic t_errors();
    for (int i = 0; i < 5; i++) begin
      i_rrirq_host.wr(8'h0d, 8'h00);
      pulse(ev(i));
      step(3);
      chk_irq(1'b0);
      rdc(8'h0c, 8'h01 << i);
      i_rrirq_host.wr(8'h0d, 8'h01 << i);
      pulse(ev(i));
      step(1);
      chk_irq(1'b1);
      rdc(8'h0c, 8'h01 << i);
      chk_irq(1'b0);
    end
  endtask : t_errors
  // FIFO levels at and beyond both bounds
  task automatic t_fifo();
    logic [3:0] lv [4] = '{4'h3, 4'h4, 4'h8, 4'h9};
    i_rrirq_host.wr(8'h0d, 8'hfe);
    rdc(8'h0d, 8'h3e);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys_i);
      fifo_level_i <= lv[i];
      fifo_level_vld_i <= 1'b1;
      @(posedge clk_sys_i);
      fifo_level_vld_i <= 1'b0;
      step(1);
      chk_irq(i % 3 == 0);
      rdc(8'h0c, (i % 3 == 0) ? 8'h20 : 8'h00);
    end
  endtask : t_fifo
  // Transmit then receive: request only after the end pulse
  task automatic t_txrx();
    for (int i = 0; i < 2; i++) begin
      pulse(ev(8 - 2 * i));
      step(3);
      chk_irq(1'b0);
      pulse(ev(7 - 2 * i));
      step(1);
      chk_irq(1'b1);
      rdc(8'h0c, 8'h80 >> i);
    end
  endtask : t_txrx
  // Ten-bit position split, each half clears on its own read; then proto clear and enable low
  task automatic t_pos_proto();
    pulse(rrirq_evt_type'({10'h001, 10'h2a5}));
    rdc(8'h0d, 8'hbe);
    rdc(8'h0d, 8'h3e);
    rdc(8'h0e, 8'ha5);
    rdc(8'h0e, 8'h00);
    pulse(ev(4));
    step(1);
    chk_irq(1'b1);
    proto();
    chk_irq(1'b0);
    rdc(8'h0c, 8'h00);
    i_rrirq_host.wr(8'h0a, 8'h12);
    enable_pin_i <= 1'b0;
    repeat (6) @(posedge clk_sys_i);
    enable_pin_i <= 1'b1;
    step(6);
    rdc(8'h0a, 8'h40);
    rdc(8'h0b, 8'h87);
  endtask : t_pos_proto
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish
  // Main sequence
  initial begin
    sys_rst_i = 1'b1;
    enable_pin_i = 1'b1;
    proto_ctrl_wr_i = 1'b0;
    evt_i = '0;
    fifo_level_i = 4'h0;
    fifo_level_vld_i = 1'b0;
    repeat (12) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    step(6);
    t_defaults();
    t_settings();
    t_errors();
    t_fifo();
    t_txrx();
    t_pos_proto();
    tally_and_finish();
  end
  // Watchdog well past the few hundred cycles the run needs
  initial begin
    repeat (5000) @(posedge clk_sys_i);
    bad_count++;
    tally_and_finish();
  end
endmodule : testbench
bind rrirq_regs rrirq_props i_rrirq_props (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .enable_pin_i(enable_pin_i),
  .req_i(req_i), .proto_ctrl_wr_i(proto_ctrl_wr_i), .rdata_o(rdata_o), .evt_i(evt_i), .fifo_level_i(fifo_level_i),
  .fifo_level_vld_i(fifo_level_vld_i), .ana_o(ana_o), .irq_o(irq_o));
